// ===== design/tcio_defs.svh
`ifndef TCIO_DEFS_SVH
`define TCIO_DEFS_SVH
// Behaviour
// (RL1) Compare mode: bit 2 of the field sets the pin's initial level.
// (RL2) Code 0x01: pin driven low on each compare match.
// (RL3) Code 0x10: pin driven high on each compare match.
// (RL4) Code 0x11: pin level inverted on each compare match.
// (RL5) Code 1000: counter latched into register on pin rising edge.
// (RL6) Code 1001: counter latched into register on pin falling edge.
// (RL7) Code 101x: counter latched on both pin edges.
// (RL8) Code 11xx: capture on each neighbor counter count-up or count-down.
// (RL9) Buffer mode A set: register C field ignored, no C events.
// (RL10) Codes 0000 and 0100 disable compare output; 0000 is reset value.

// APB register offsets (byte addresses)
`define TCIO_OFF_CTRL 12'h000
`define TCIO_OFF_COUNT 12'h004
`define TCIO_OFF_GRA 12'h008
`define TCIO_OFF_GRC 12'h00C
`define TCIO_OFF_STAT 12'h010
// Control register field positions
`define TCIO_SEL_A_LSB 0
`define TCIO_SEL_C_LSB 4
`define TCIO_BUF_A_BIT 8
`define TCIO_RUN_BIT 9
// Reset values
`define TCIO_SEL_RST 4'h0
`define TCIO_CNT_RST 16'h0000
`define TCIO_GR_RST 16'hFFFF
`endif

// ===== design/tcio_pkg.sv
package tcio_pkg;
    typedef logic [3:0] tcio_sel_t;
    typedef logic [15:0] tcio_word_t;
    typedef enum logic [2:0] {
        TCIO_IDLE = 3'b001,
        TCIO_SETUP = 3'b010,
        TCIO_ACCESS = 3'b100
    } tcio_apb_e;
endpackage

// ===== design/tcio_chan_if.sv
`timescale 1ns/10ps
interface tcio_chan_if;
    import tcio_pkg::*;
    tcio_sel_t sel;
    logic enable;
    logic match;
    logic pinIn;
    logic countStep;
    logic pinOut;
    logic capture;
    modport ctl (output sel, enable, match, pinIn, countStep, input pinOut, capture);
    modport unit (input sel, enable, match, pinIn, countStep, output pinOut, capture);
endinterface // tcio_chan_if

// ===== design/tcio_unit.sv
`timescale 1ns/10ps
`include "tcio_defs.svh"
module tcio_unit
    import tcio_pkg::*;
(
    input wire logic sys_clk, // Timer clock
    input wire logic rst_b, // Async reset, low
    tcio_chan_if.unit ch // Channel controls
);
    logic pinOut_r, pinOut_nxt;
    logic pinPrev_r, pinPrev_nxt;
    tcio_sel_t selPrev_r, selPrev_nxt;
    logic cmpPrev_r, cmpPrev_nxt;
    logic capture_r, capture_nxt;
    logic rise, fall, cmpMode;

    assign cmpMode = ~ch.sel[3] & ch.enable;
    assign rise = ch.pinIn & ~pinPrev_r;
    assign fall = ~ch.pinIn & pinPrev_r;

    always_comb
    begin
        pinOut_nxt = pinOut_r;
        pinPrev_nxt = ch.pinIn;
        selPrev_nxt = ch.sel;
        cmpPrev_nxt = cmpMode;
        capture_nxt = 1'b0;
        if (cmpMode)
        begin
            // (RL1) initial level on entry or new code
            // Whole code compared, bit 2 alone misses new compare codes that keep bit 2
            if (!cmpPrev_r || (ch.sel != selPrev_r))
                pinOut_nxt = ch.sel[2];
            // (RL10) codes x00 hold pin
            if (ch.match)
            begin
                case (ch.sel[1:0])
                    // (RL2) low on match
                    2'b01: pinOut_nxt = 1'b0;
                    // (RL3) high on match
                    2'b10: pinOut_nxt = 1'b1;
                    // (RL4) toggle on match
                    2'b11: pinOut_nxt = ~pinOut_r;
                    default: pinOut_nxt = pinOut_r;
                endcase
            end
        end
        else if (ch.enable)
        begin
            // (RL8) neighbor counter source
            if (ch.sel[2])
                capture_nxt = ch.countStep;
            // (RL7) both edges
            else if (ch.sel[1])
                capture_nxt = rise | fall;
            // (RL6) falling edge
            else if (ch.sel[0])
                capture_nxt = fall;
            // (RL5) rising edge
            else
                capture_nxt = rise;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinOut_r <= 1'b0;
            pinPrev_r <= 1'b0;
            selPrev_r <= `TCIO_SEL_RST;
            cmpPrev_r <= 1'b0;
            capture_r <= 1'b0;
        end
        else
        begin
            pinOut_r <= pinOut_nxt;
            pinPrev_r <= pinPrev_nxt;
            selPrev_r <= selPrev_nxt;
            cmpPrev_r <= cmpPrev_nxt;
            capture_r <= capture_nxt;
        end
    end

    assign ch.pinOut = pinOut_r;
    assign ch.capture = capture_r;
endmodule // tcio_unit

// ===== design/tcio_top.sv
`timescale 1ns/10ps
`include "tcio_defs.svh"
module tcio_top
    import tcio_pkg::*;
(
    input wire logic sys_clk, // Timer clock, 40 MHz
    input wire logic rst_b, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic pinAIn, // Pin A level in
    input wire logic pinCIn, // Pin C level in
    input wire logic neighborStep, // Neighbor counter step pulse
    output logic pinAOut, // Pin A level out
    output logic pinAOe, // Pin A drive enable
    output logic pinCOut, // Pin C level out
    output logic pinCOe // Pin C drive enable
);
    tcio_chan_if chA();
    tcio_chan_if chC();

    tcio_sel_t selA_r, selA_nxt, selC_r, selC_nxt;
    logic bufA_r, bufA_nxt, run_r, run_nxt;
    tcio_word_t count_r, count_nxt, grA_r, grA_nxt, grC_r, grC_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [3:0] stat_r, stat_nxt;
    logic [3:0] oe_r, oe_nxt;
    logic wrEn, rdEn, hit;
    logic [31:0] rdVal;
    logic capA_d, capC_d;

    // Writes taken in the access phase, reads sampled in the setup phase, answered with zero wait states
    assign wrEn = psel & penable & pwrite & pready_r;
    assign rdEn = psel & ~penable & ~pwrite;

    assign chA.sel = selA_r;
    assign chA.enable = 1'b1;
    assign chA.match = run_r & (count_r == grA_r);
    assign chA.pinIn = pinAIn;
    assign chA.countStep = neighborStep;
    assign chC.sel = selC_r;
    // (RL9) buffer mode blocks C
    assign chC.enable = ~bufA_r;
    assign chC.match = run_r & (count_r == grC_r);
    assign chC.pinIn = pinCIn;
    assign chC.countStep = neighborStep;

    tcio_unit uA (.sys_clk(sys_clk), .rst_b(rst_b), .ch(chA));
    tcio_unit uC (.sys_clk(sys_clk), .rst_b(rst_b), .ch(chC));

    assign capA_d = chA.capture;
    assign capC_d = chC.capture;

    always_comb
    begin
        hit = 1'b1;
        case (paddr)
            `TCIO_OFF_CTRL: rdVal = {22'h00_0000, run_r, bufA_r, selC_r, selA_r};
            `TCIO_OFF_COUNT: rdVal = {16'h0000, count_r};
            `TCIO_OFF_GRA: rdVal = {16'h0000, grA_r};
            `TCIO_OFF_GRC: rdVal = {16'h0000, grC_r};
            `TCIO_OFF_STAT: rdVal = {28'h000_0000, stat_r};
            default:
            begin
                rdVal = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        selA_nxt = selA_r;
        selC_nxt = selC_r;
        bufA_nxt = bufA_r;
        run_nxt = run_r;
        count_nxt = run_r ? count_r + 16'h0001 : count_r;
        grA_nxt = grA_r;
        grC_nxt = grC_r;
        prdata_nxt = prdata_r;
        pready_nxt = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~hit;
        stat_nxt = {chC.pinOut, chA.pinOut, capC_d, capA_d};
        if (rdEn)
            prdata_nxt = rdVal;
        if (wrEn & hit)
        begin
            case (paddr)
                `TCIO_OFF_CTRL:
                begin
                    selA_nxt = pwdata[`TCIO_SEL_A_LSB +: 4];
                    selC_nxt = pwdata[`TCIO_SEL_C_LSB +: 4];
                    bufA_nxt = pwdata[`TCIO_BUF_A_BIT];
                    run_nxt = pwdata[`TCIO_RUN_BIT];
                end
                `TCIO_OFF_COUNT: count_nxt = pwdata[15:0];
                `TCIO_OFF_GRA: grA_nxt = pwdata[15:0];
                `TCIO_OFF_GRC: grC_nxt = pwdata[15:0];
                default: stat_nxt = stat_r;
            endcase
        end
        // (RL5) capture loads general register
        if (capA_d)
            grA_nxt = count_r;
        if (capC_d)
            grC_nxt = count_r;
        // (RL10) drive only when compare active
        oe_nxt[0] = ~selA_r[3] & (selA_r[1:0] != 2'b00);
        oe_nxt[1] = ~bufA_r & ~selC_r[3] & (selC_r[1:0] != 2'b00);
        oe_nxt[2] = chA.pinOut;
        oe_nxt[3] = chC.pinOut;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            selA_r <= `TCIO_SEL_RST;
            selC_r <= `TCIO_SEL_RST;
            bufA_r <= 1'b0;
            run_r <= 1'b0;
            count_r <= `TCIO_CNT_RST;
            grA_r <= `TCIO_GR_RST;
            grC_r <= `TCIO_GR_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            stat_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else
        begin
            selA_r <= selA_nxt;
            selC_r <= selC_nxt;
            bufA_r <= bufA_nxt;
            run_r <= run_nxt;
            count_r <= count_nxt;
            grA_r <= grA_nxt;
            grC_r <= grC_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            stat_r <= stat_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pinAOe = oe_r[0];
    assign pinCOe = oe_r[1];
    assign pinAOut = oe_r[2];
    assign pinCOut = oe_r[3];
endmodule // tcio_top

// ===== dv/tcio_top_props.sv
`timescale 1ns/10ps
module tcio_top_props (
    input wire logic sys_clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic pinAOe, // Drive A
    input wire logic pinCOe // Drive C
);
    logic [9:0] ctrl_r;
    logic [1:0] quiet_r;
    logic wrCtrl;
    assign wrCtrl = psel && penable && pready && pwrite && paddr == 12'h000;
    // Shadow control; enables judged only once settled
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r <= 10'h000;
            quiet_r <= 2'h0;
        end
        else
        begin
            ctrl_r <= wrCtrl ? pwdata[9:0] : ctrl_r;
            quiet_r <= wrCtrl ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence setupS;
        psel && !penable;
    endsequence
    AST_READY: assert property (setupS |=> pready) else $error("no ready");
    AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
    AST_QUAL: assert property (pready |-> psel && penable) else $error("stray ready");
    AST_ERR: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
        else $error("bad error flag");
    AST_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped data");
    AST_CTRL: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == {22'h0, ctrl_r})
        else $error("ctrl readback");
    AST_AOE: assert property (quiet_r == 2'h3 |-> pinAOe == (!ctrl_r[3] && ctrl_r[1:0] != 2'h0))
        else $error("pin A drive");
    AST_COE: assert property (quiet_r == 2'h3 |-> pinCOe == (!ctrl_r[7] && ctrl_r[5:4] != 2'h0 && !ctrl_r[8]))
        else $error("pin C drive");
endmodule // tcio_top_props
bind tcio_top tcio_top_props chk (.*);

// ===== dv/tcio_pin_model.sv
`timescale 1ns/10ps
module tcio_pin_model (
    input wire logic sys_clk, // Clock
    input wire logic extA, // Outside level A
    input wire logic extC, // Outside level C
    input wire logic stepReq, // Toggle for a step
    input wire logic pinAOut, // Device level A
    input wire logic pinAOe, // Device drives A
    input wire logic pinCOut, // Device level C
    input wire logic pinCOe, // Device drives C
    output logic pinAIn, // Wire A
    output logic pinCIn, // Wire C
    output logic neighborStep // Step pulse
);
    logic stepQ = 1'b0;
    // Wire follows the device whenever it drives
    assign pinAIn = pinAOe ? pinAOut : extA;
    assign pinCIn = pinCOe ? pinCOut : extC;
    assign neighborStep = stepReq ^ stepQ;
    always @(posedge sys_clk)
    begin
        stepQ <= stepReq;
    end
endmodule // tcio_pin_model

// ===== dv/tcio_top_bench.sv
`timescale 1ns/10ps
module tcio_top_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, exp;
    logic pready, pslverr, pinAIn, pinCIn, neighborStep, pinAOut, pinAOe, pinCOut, pinCOe;
    logic extA = 1'b0, extC = 1'b0, stepReq = 1'b0;
    int mismatches = 0, samples_checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    tcio_top dut (.*);
    tcio_pin_model pins (.*);
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Load count, then rise, fall or step
    task ev(input logic [31:0] cnt, input int kind);
        apb(1'b1, 12'h004, cnt);
        @(posedge sys_clk);
        if (kind == 0) extA <= 1'b1;
        else if (kind == 1) extA <= 1'b0;
        else stepReq <= ~stepReq;
        cyc(4);
        apb(1'b0, 12'h008, 32'h0);
    endtask
    task t_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdat, 32'h0000_FFFF);
        apb(1'b0, 12'h020, 32'h0);
        chk(rdat, 32'h0);
        $display("reset test done");
    endtask
    task t_compare;
        logic [3:0] code [4];
        code = '{4'h5, 4'h2, 4'h7, 4'h3};
        for (int ch = 0; ch < 2; ch++)
            for (int i = 0; i < 4; i++)
            begin
                apb(1'b1, 12'h000, {28'h0, code[i]} << (ch * 4));
                cyc(4);
                chk(ch ? pinCOut : pinAOut, code[i][2]);
                apb(1'b1, 12'h004, 32'h0);
                apb(1'b1, 12'h008 + 12'(ch * 4), 32'h0000_0008);
                apb(1'b1, 12'h000, ({28'h0, code[i]} << (ch * 4)) | 32'h0000_0200);
                cyc(16);
                chk(ch ? pinCOut : pinAOut, !code[i][2]);
            end
        $display("compare test done");
    endtask
    task t_capture;
        logic [3:0] code [5];
        code = '{4'h8, 4'h9, 4'hB, 4'hC, 4'hF};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 12'h000, 32'h0000_01C0 | code[i]);
            apb(1'b1, 12'h008, 32'h0);
            apb(1'b1, 12'h00C, 32'h0000_0055);
            exp = 32'h0;
            if (code[i] == 4'h8 || code[i][3:1] == 3'b101) exp = 32'h0000_0A01;
            ev(32'h0000_0A01, 0);
            chk(rdat, exp);
            if (code[i] == 4'h9 || code[i][3:1] == 3'b101) exp = 32'h0000_0B02;
            ev(32'h0000_0B02, 1);
            chk(rdat, exp);
            if (code[i][3:2] == 2'b11) exp = 32'h0000_0C03;
            ev(32'h0000_0C03, 2);
            chk(rdat, exp);
            apb(1'b0, 12'h00C, 32'h0);
            chk(rdat, 32'h0000_0055);
        end
        $display("capture test done");
    endtask
    // Compare entry from capture, new code with same bit 2, then reset with the counter stopped
    task t_entry;
        apb(1'b1, 12'h000, 32'h0000_000C);
        apb(1'b1, 12'h000, 32'h0000_0005);
        cyc(4);
        chk(pinAOut, 1'b1);
        chk(pinAOe, 1'b1);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h008, 32'h0000_0008);
        apb(1'b1, 12'h000, 32'h0000_0205);
        cyc(16);
        chk(pinAOut, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0007);
        cyc(4);
        chk(pinAOut, 1'b1);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0);
        chk(pinAOut, 1'b0);
        $display("entry test done");
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset;
        t_compare;
        t_capture;
        t_entry;
        summarize;
    end
    initial
    begin
        #200000;
        mismatches++;
        summarize;
    end
endmodule // tcio_top_bench
